// >>> page_history_recording.sv
// page history recorder: segment registers, hit/miss history decision and
// the read-modify-write of referenced/changed bits in memory entries
// assumes the table walker supplies the located entry address with each access,
// and that the memory port answers on the same clock
`timescale 1ns/1ns

// Behaviour
// RULE_01: effective space split into 256 MB segments chosen by top address bits.
// RULE_02: 4 KB pages mapped through a 52-bit virtual address.
// RULE_03: a block hit wins; otherwise effective to virtual to physical.
// RULE_04: history kept only for paged accesses, not block hits or direct-store.
// RULE_05: history kept only while the matching translation enable is set.
// RULE_06: hit with pattern 10: reads nothing, writes search to set changed.
// RULE_07: hit with pattern 11: no history action for reads or writes.
// RULE_08: loaded entries always have referenced set; 00 and 01 never occur.
// RULE_09: on a miss the search sets the bits the access requires.
// RULE_10: software clearing memory bits must invalidate matching buffer entries.
// RULE_11: cache touches missing all translation are no-ops without search.
// RULE_12: updates are untranslated single-beat reads and byte writes.
// RULE_13: a referenced bit found zero in memory is set.
// RULE_14: hardware never clears a referenced bit.
// RULE_15: store hit with changed clear sets entry bit and searches memory.
// RULE_16: changed set only for permitted stores on the execution path.
// RULE_17: changed may be set for failed conditional or preempted stores.
// RULE_18: cache touches may set referenced but never changed.
// RULE_19: referenced may be set for unneeded or protection-blocked accesses.
// RULE_20: history writes are nonguarded, cacheable and coherency-required.
module page_history_recording
  import phr_pkg::*;
(
  // clock and reset
  input  wire logic              clk_in,
  input  wire logic              rstn_in,
  // register port
  input  wire logic [7:0]        reg_addr_in,
  input  wire logic [31:0]       reg_wdata_in,
  input  wire logic              reg_we_in,
  input  wire logic              reg_re_in,
  output logic      [31:0]       reg_rdata_out,
  // translation mode
  input  wire logic              instr_translate_enable_in,
  input  wire logic              data_translate_enable_in,
  // access from the translation pipeline
  input  wire access_t           acc_in,
  output logic                   acc_ready_out,
  output logic                   tlb_set_c_out,
  output logic                   page_path_out,
  output logic      [VA_W-1:0]   va_out,
  output logic                   done_out,
  // memory port for history updates
  output mem_req_t               mem_out,
  input  wire logic              mem_ack_in,
  input  wire logic [31:0]       mem_rdata_in
);

  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  core_state_t q;
  core_state_t d;

  logic [VA_W-1:0] va_w;
  logic            direct_store_w;
  logic            page_path_w;
  decision_t       dec_w;
  logic            take_acc;
  logic [7:0]      old_byte;
  logic [7:0]      new_byte;
  logic            seg_hit;
  logic [3:0]      seg_idx;

  // ---------------------------------------------------------------------------
  // translation front and history decision
  // ---------------------------------------------------------------------------
  seg_translate u_seg_translate (
    .ea_in            (acc_in.ea),
    .bat_hit_in       (acc_in.bat_hit),
    .seg_in           (q.seg),
    .va_out           (va_w),
    .direct_store_out (direct_store_w),
    .page_path_out    (page_path_w)
  );

  history_decide u_history_decide (
    .acc_in                    (acc_in),
    .instr_translate_enable_in (instr_translate_enable_in),
    .data_translate_enable_in  (data_translate_enable_in),
    .direct_store_in           (direct_store_w),
    .record_en_in              (q.record_en),
    .dec_out                   (dec_w)
  );

  // accesses are only taken while idle; the pipeline holds them otherwise
  assign take_acc = acc_in.valid & q.acc_ready;

  // the engine keeps its own copy of the history lane, so a register read
  // landing on the memory answer cannot corrupt the read-modify-write
  assign old_byte = q.wbyte;

  // only ever or-in bits, so a clear by hardware cannot happen        [RULE_13] [RULE_14]
  assign new_byte = old_byte | R_BYTE_MASK | (q.need_c ? C_BYTE_MASK : 8'h00);

  assign seg_hit = (reg_addr_in[7:6] == SEG_WINDOW);
  assign seg_idx = reg_addr_in[5:2];

  // ---------------------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------------------
  always_comb begin
    d = q;
    d.tlb_set_c = 1'b0;
    d.done      = 1'b0;

    // register writes
    if (reg_we_in) begin
      if (seg_hit) begin
        d.seg[seg_idx] = reg_wdata_in;
      end else begin
        case (reg_addr_in)
          CTRL_OFS: begin
            d.record_en = reg_wdata_in[0];
          end
          COUNT_OFS: begin
            d.upd_count = 32'h0000_0000;
          end
          default: begin
          end
        endcase
      end
    end

    // register reads, answered one cycle later, unmapped reads as zero
    d.rdata = q.rdata;
    if (reg_re_in) begin
      if (seg_hit) begin
        d.rdata = q.seg[seg_idx];
      end else begin
        case (reg_addr_in)
          CTRL_OFS:     d.rdata = {31'h0000_0000, q.record_en};
          STATUS_OFS:   d.rdata = {29'h0000_0000, q.wrote_c, q.wrote_r, ~q.acc_ready};
          COUNT_OFS:    d.rdata = q.upd_count;
          LAST_PTE_OFS: d.rdata = q.pte_addr;
          default:      d.rdata = 32'h0000_0000;
        endcase
      end
    end

    // update engine
    case (q.fsm)
      ST_IDLE: begin
        if (take_acc) begin
          d.va        = va_w;
          d.page_path = page_path_w;
          if (dec_w.start) begin
            d.fsm       = ST_READ;
            d.acc_ready = 1'b0;
            d.pte_addr  = acc_in.pte_addr;
            d.need_c    = dec_w.need_c;
            d.tlb_set_c = dec_w.tlb_set_c;
            d.wrote_r   = 1'b0;
            d.wrote_c   = 1'b0;
            // single-beat untranslated read of the entry word       [RULE_12]
            d.mem.req         = 1'b1;
            d.mem.we          = 1'b0;
            d.mem.single_beat = 1'b1;
            d.mem.byte_size   = 1'b0;
            d.mem.addr        = acc_in.pte_addr;
            d.mem.wdata       = 8'h00;
            d.mem.wimg        = WIMG_HISTORY; // [RULE_20]
          end else begin
            d.done = 1'b1;
          end
        end
      end

      ST_READ: begin
        if (mem_ack_in) begin
          d.mem.req = 1'b0;
          d.wbyte   = mem_rdata_in[HIST_LANE*8 +: 8];
          d.fsm     = ST_WRITE;
        end
      end

      ST_WRITE: begin
        if (!q.mem.req) begin
          if (new_byte == old_byte) begin
            // bits already set in memory; skip the write
            d.fsm       = ST_IDLE;
            d.acc_ready = 1'b1;
            d.done      = 1'b1;
          end else begin
            // byte write of only the lane holding the history bits   [RULE_12]
            d.mem.req         = 1'b1;
            d.mem.we          = 1'b1;
            d.mem.single_beat = 1'b1;
            d.mem.byte_size   = 1'b1;
            d.mem.addr        = q.pte_addr + HIST_BYTE_OFS;
            d.mem.wdata       = new_byte;
            d.mem.wimg        = WIMG_HISTORY; // [RULE_20]
            d.wbyte           = new_byte;
            d.wrote_r         = (old_byte & R_BYTE_MASK) == 8'h00;
            d.wrote_c         = q.need_c && ((old_byte & C_BYTE_MASK) == 8'h00);
          end
        end else if (mem_ack_in) begin
          d.mem.req   = 1'b0;
          d.mem.we    = 1'b0;
          d.upd_count = q.upd_count + 32'h0000_0001;
          d.fsm       = ST_IDLE;
          d.acc_ready = 1'b1;
          d.done      = 1'b1;
        end
      end

      default: begin
        d.fsm       = ST_IDLE;
        d.acc_ready = 1'b1;
        d.mem.req   = 1'b0;
      end
    endcase

  end

  // ---------------------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      q           <= '0;
      q.record_en <= CTRL_RECORD_RESET;
      q.acc_ready <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // ---------------------------------------------------------------------------
  // outputs, all straight from flops
  // ---------------------------------------------------------------------------
  assign reg_rdata_out = q.rdata;
  assign acc_ready_out = q.acc_ready;
  assign tlb_set_c_out = q.tlb_set_c;
  assign page_path_out = q.page_path;
  assign va_out        = q.va;
  assign done_out      = q.done;
  assign mem_out       = q.mem;

endmodule : page_history_recording

// >>> phr_pkg.sv
// constants, carrier structs and state types for the page history recorder
// assumes one 25 MHz clock domain shared by the core, the table walker and the bus port
package phr_pkg;

  // ---------------------------------------------------------------------------
  // address geometry
  // ---------------------------------------------------------------------------
  localparam int SEG_COUNT  = 16;
  localparam int EA_W       = 32;
  localparam int VSID_W     = 24;
  localparam int SEG_OFS_W  = 28;
  localparam int VA_W       = VSID_W + SEG_OFS_W;
  localparam int SEG_T_POS  = 31;

  // ---------------------------------------------------------------------------
  // register map, byte offsets on the register port
  // ---------------------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS     = 8'h00;
  localparam logic [7:0] STATUS_OFS   = 8'h04;
  localparam logic [7:0] COUNT_OFS    = 8'h08;
  localparam logic [7:0] LAST_PTE_OFS = 8'h0C;
  localparam logic [1:0] SEG_WINDOW   = 2'h1;
  localparam logic       CTRL_RECORD_RESET = 1'b1;

  // ---------------------------------------------------------------------------
  // history bit layout in the lower entry word and bus attributes
  // ---------------------------------------------------------------------------
  localparam int          R_BIT_POS     = 9;
  localparam int          C_BIT_POS     = 8;
  localparam int          HIST_LANE     = R_BIT_POS / 8;
  localparam logic [7:0]  R_BYTE_MASK   = 8'(1 << (R_BIT_POS % 8));
  localparam logic [7:0]  C_BYTE_MASK   = 8'(1 << (C_BIT_POS % 8));
  localparam logic [31:0] HIST_BYTE_OFS = 32'h0000_0002;
  localparam logic [3:0]  WIMG_HISTORY  = 4'h2;

  // ---------------------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic            valid;
    logic            is_instr;
    logic            is_write;
    logic            is_touch;
    logic            bat_hit;
    logic            tlb_hit;
    logic            tlb_c;
    logic            prot_ok;
    logic            committed;
    logic [EA_W-1:0] ea;
    logic [31:0]     pte_addr;
  } access_t;

  typedef struct packed {
    logic start;
    logic need_c;
    logic tlb_set_c;
  } decision_t;

  typedef struct packed {
    logic        req;
    logic        we;
    logic        single_beat;
    logic        byte_size;
    logic [31:0] addr;
    logic [7:0]  wdata;
    logic [3:0]  wimg;
  } mem_req_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_READ  = 2'b01,
    ST_WRITE = 2'b10
  } fsm_state_t;

  typedef struct packed {
    fsm_state_t                   fsm;
    logic [SEG_COUNT-1:0][31:0]   seg;
    logic                         record_en;
    logic [31:0]                  upd_count;
    logic [31:0]                  rdata;
    logic [31:0]                  pte_addr;
    logic                         need_c;
    logic [7:0]                   wbyte;
    logic                         wrote_r;
    logic                         wrote_c;
    logic                         acc_ready;
    logic                         tlb_set_c;
    logic                         done;
    logic                         page_path;
    logic [VA_W-1:0]              va;
    mem_req_t                     mem;
  } core_state_t;

endpackage : phr_pkg

// >>> seg_translate.sv
// segment selection and virtual address formation for one access
// assumes the segment registers are held by the caller
`timescale 1ns/1ns
module seg_translate
  import phr_pkg::*;
(
  // access side
  input  wire logic [EA_W-1:0]                ea_in,
  input  wire logic                           bat_hit_in,
  input  wire logic [SEG_COUNT-1:0][31:0]     seg_in,
  // results
  output logic      [VA_W-1:0]                va_out,
  output logic                                direct_store_out,
  output logic                                page_path_out
);

  logic [31:0] seg_word;

  // the top four address bits pick one 256 MB segment                   [RULE_01]
  assign seg_word = seg_in[ea_in[EA_W-1:SEG_OFS_W]];

  // vsid concatenated with page index and 4 KB byte offset              [RULE_02]
  assign va_out = {seg_word[VSID_W-1:0], ea_in[SEG_OFS_W-1:0]};

  assign direct_store_out = seg_word[SEG_T_POS];

  // a block hit overrides the two-step segment/page path                [RULE_03]
  assign page_path_out = ~bat_hit_in;

endmodule : seg_translate

// >>> history_decide.sv
// decides whether an access needs a history update and which bits
// assumes the access struct is stable in the cycle it is offered
`timescale 1ns/1ns
module history_decide
  import phr_pkg::*;
(
  // access and mode
  input  wire access_t   acc_in,
  input  wire logic      instr_translate_enable_in,
  input  wire logic      data_translate_enable_in,
  input  wire logic      direct_store_in,
  input  wire logic      record_en_in,
  // verdict
  output decision_t      dec_out
);

  logic xlate_on;
  logic paged;
  logic c_ok;

  // each access class looks at its own translation enable                [RULE_05]
  assign xlate_on = acc_in.is_instr ? instr_translate_enable_in : data_translate_enable_in;
  // no history for block hits or direct-store segments                  [RULE_04]
  assign paged = xlate_on & ~acc_in.bat_hit & ~direct_store_in & record_en_in;
  // changed only for permitted, committed stores; touches never          [RULE_16] [RULE_18]
  // committed covers failed conditional stores and preempted stores      [RULE_17]
  assign c_ok = acc_in.is_write & ~acc_in.is_touch & acc_in.prot_ok & acc_in.committed;

  always_comb begin
    dec_out = '0;
    if (acc_in.valid && paged) begin
      if (acc_in.tlb_hit) begin
        // entry referenced is always 1, so only 10 vs 11 matters       [RULE_08]
        // 10 with a store: set entry bit and search to set memory bit  [RULE_06] [RULE_15]
        // 11, or any read: nothing to do                               [RULE_07]
        if (c_ok && !acc_in.tlb_c) begin
          dec_out.start     = 1'b1;
          dec_out.need_c    = 1'b1;
          dec_out.tlb_set_c = 1'b1;
        end
      end else if (!acc_in.is_touch) begin
        // miss search marks the entry as the access requires           [RULE_09] [RULE_19]
        dec_out.start  = 1'b1;
        dec_out.need_c = c_ok;
      end
      // a touch that misses is a no-op with no search                  [RULE_11]
    end
  end

endmodule : history_decide

// >>> phr_mem.sv
// memory model holding entry words, the far side of the history port
// assumes one request at a time, held up until acknowledged
`timescale 1ns/1ns
module phr_mem
  import phr_pkg::*;
(
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        rstn_in,
  // request side
  input  wire mem_req_t    mem_in,
  input  wire logic        slow_in,
  // answer side
  output logic             ack_out,
  output logic [31:0]      rdata_out
);
  logic [15:0][31:0] word_q;
  logic [1:0]        wait_q;

  always @(posedge clk_in) begin
    if (!rstn_in) begin
      ack_out   <= 1'b0;
      wait_q    <= 2'h0;
      rdata_out <= 32'h5A5A_A5A5;
    end else if (mem_in.req && !ack_out && (!slow_in || wait_q == 2'h3)) begin
      ack_out <= 1'b1;
      wait_q  <= 2'h0;
      if (!mem_in.we) begin
        rdata_out <= word_q[mem_in.addr[5:2]];
      end else begin
        // lane chosen by address, big-endian, so a misplaced byte lands in the wrong bits
        word_q[mem_in.addr[5:2]][31-8*mem_in.addr[1:0] -: 8] <= mem_in.wdata;
      end
    end else begin
      ack_out   <= 1'b0;
      wait_q    <= wait_q + (mem_in.req ? 2'h1 : 2'h0);
      // released data toggles so a stale capture never looks right
      rdata_out <= ~rdata_out;
    end
  end
endmodule : phr_mem

// >>> phr_asserts.sv
// port checker for the page history recorder, bound to its top module
// assumes segment and record enable settings change only over the register port
`timescale 1ns/1ns
module phr_checker
  import phr_pkg::*;
(
  // clock, reset, register writes
  input wire logic            clk_in,
  input wire logic            rstn_in,
  input wire logic [7:0]      reg_addr_in,
  input wire logic [31:0]     reg_wdata_in,
  input wire logic            reg_we_in,
  // access side
  input wire logic            instr_translate_enable_in,
  input wire logic            data_translate_enable_in,
  input wire access_t         acc_in,
  input wire logic            acc_ready_out,
  input wire logic            tlb_set_c_out,
  input wire logic            page_path_out,
  input wire logic [VA_W-1:0] va_out,
  input wire logic            done_out,
  // memory port
  input wire mem_req_t        mem_out,
  input wire logic            mem_ack_in
);
  logic [15:0] ds_q;
  logic        rec_q;
  logic        take;
  logic        paged;
  logic        c_ok;

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      ds_q  <= '0;
      rec_q <= 1'b1;
    end else if (reg_we_in && reg_addr_in == CTRL_OFS) begin
      rec_q <= reg_wdata_in[0];
    end else if (reg_we_in && reg_addr_in[7:6] == SEG_WINDOW) begin
      ds_q[reg_addr_in[5:2]] <= reg_wdata_in[SEG_T_POS];
    end
  end

  assign take  = acc_in.valid && acc_ready_out;
  assign paged = !acc_in.bat_hit && !ds_q[acc_in.ea[31:28]] && rec_q && !acc_in.is_touch
                 && (acc_in.is_instr ? instr_translate_enable_in : data_translate_enable_in);
  assign c_ok  = acc_in.is_write && acc_in.prot_ok && acc_in.committed;

  default clocking @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  // ------------------------------------------------
  // history update sequences
  // ------------------------------------------------
  sequence rd_issue;
    mem_out.req && !mem_out.we && mem_out.addr == $past(acc_in.pte_addr);
  endsequence
  sequence wr_or_skip;
    done_out || mem_out.req && mem_out.we && mem_out.addr == $past(mem_out.addr, 2) + HIST_BYTE_OFS;
  endsequence

  hist_attr_a: assert property (
    mem_out.req |-> mem_out.wimg == WIMG_HISTORY && mem_out.single_beat
                    && (mem_out.byte_size || !mem_out.we)) else $error("bad history attributes");
  req_hold_a: assert property (
    mem_out.req && !mem_ack_in |=> mem_out.req && $stable(mem_out.addr)) else $error("req dropped");
  no_action_a: assert property (
    take && !paged |=> done_out && !mem_out.req && !tlb_set_c_out) else $error("unexpected update");
  hit_quiet_a: assert property (
    take && paged && acc_in.tlb_hit && !(c_ok && !acc_in.tlb_c) |=> done_out && !mem_out.req)
    else $error("hit started a search");
  hit_store_a: assert property (
    take && paged && acc_in.tlb_hit && c_ok && !acc_in.tlb_c |=> tlb_set_c_out ##0 rd_issue)
    else $error("store hit missed changed update");
  miss_walk_a: assert property (
    take && paged && !acc_in.tlb_hit |=> !tlb_set_c_out ##0 rd_issue) else $error("miss no search");
  byte_write_a: assert property (
    mem_out.req && !mem_out.we && mem_ack_in |=> !mem_out.req ##1 wr_or_skip)
    else $error("history write misplaced");
  r_kept_a: assert property (
    mem_out.req && mem_out.we |-> (mem_out.wdata & R_BYTE_MASK) != 8'h00)
    else $error("referenced bit cleared");
  va_form_a: assert property (
    take |=> va_out[SEG_OFS_W-1:0] == $past(acc_in.ea[SEG_OFS_W-1:0])
             && page_path_out == !$past(acc_in.bat_hit)) else $error("virtual address wrong");
endmodule : phr_checker

bind page_history_recording phr_checker u_phr_checker (.*);

// >>> page_history_recording_test.sv
// self-checking bench: register port, random accesses, history bytes in memory
// assumes phr_mem answers the memory port and phr_checker is bound to the design
`timescale 1ns/1ns
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module page_history_recording_test
  import phr_pkg::*;
;
  logic              clk_in = 1'b0;
  logic              rstn_in = 1'b0;
  logic [7:0]        reg_addr_in = 8'h00;
  logic [31:0]       reg_wdata_in = 32'h0;
  logic              reg_we_in = 1'b0;
  logic              reg_re_in = 1'b0;
  logic              instr_translate_enable_in = 1'b1;
  logic              data_translate_enable_in = 1'b1;
  access_t           acc_in = '0;
  logic              slow = 1'b0;
  logic [31:0]       reg_rdata_out, mem_rdata_in;
  logic              acc_ready_out, tlb_set_c_out, page_path_out, done_out, mem_ack_in;
  logic [VA_W-1:0]   va_out;
  mem_req_t          mem_out;
  int                n_errors = 0;
  int                num_checks = 0;
  int                seed = 32'h9f35226b;
  logic [15:0][31:0] seg_m = '0;
  logic              rec = 1'b1;
  int                n_upd = 0;
  logic [31:0]       last_pte = 32'h0;
  logic [1:0]        st_exp = 2'b00;

  page_history_recording u_page_history_recording (.*);
  phr_mem u_phr_mem (.clk_in(clk_in), .rstn_in(rstn_in), .mem_in(mem_out), .slow_in(slow),
                     .ack_out(mem_ack_in), .rdata_out(mem_rdata_in));

  always #20 clk_in = ~clk_in;

  // ------------------------------------------------
  // tasks and expectations
  // ------------------------------------------------
  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : close_out

  task automatic reg_op(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    reg_we_in    <= we;
    reg_re_in    <= !we;
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    @(posedge clk_in);
    reg_we_in <= 1'b0;
    reg_re_in <= 1'b0;
    @(negedge clk_in);
  endtask : reg_op

  function automatic logic [1:0] exp_bits(input access_t a);
    if (a.bat_hit || seg_m[a.ea[31:28]][SEG_T_POS] || !rec || a.is_touch ||
        !(a.is_instr ? instr_translate_enable_in : data_translate_enable_in)) return 2'b00;
    if (a.tlb_hit) return (a.is_write && a.prot_ok && a.committed && !a.tlb_c) ? 2'b11 : 2'b00;
    return {1'b1, a.is_write && a.prot_ok && a.committed};
  endfunction : exp_bits

  task automatic run_acc(input access_t a);
    logic [31:0] w;
    logic [1:0]  e;
    logic        sc;
    int          k;
    @(posedge clk_in);
    w  = u_phr_mem.word_q[a.pte_addr[5:2]];
    e  = exp_bits(a);
    sc = 1'b0;
    k  = 0;
    acc_in <= a;
    @(posedge clk_in);
    acc_in.valid <= 1'b0;
    do begin
      @(negedge clk_in);
      sc = sc | tlb_set_c_out;
      k++;
    end while (done_out !== 1'b1 && k < 40);
    if (done_out !== 1'b1) begin
      n_errors++;
      close_out();
    end
    if (e != 2'b00) begin
      last_pte = a.pte_addr;
      st_exp   = {e[0] & !w[C_BIT_POS], !w[R_BIT_POS]};
      if ((w | (32'(e) << C_BIT_POS)) != w) begin
        n_upd++;
      end
    end
    w = w | (32'(e) << C_BIT_POS);
    `CHK("entry word", w, u_phr_mem.word_q[a.pte_addr[5:2]])
    `CHK("set changed", a.tlb_hit && e[0], sc)
    `CHK("virt addr", {seg_m[a.ea[31:28]][VSID_W-1:0], a.ea[SEG_OFS_W-1:0]}, va_out)
    `CHK("page path", !a.bat_hit, page_path_out)
  endtask : run_acc

  // ------------------------------------------------
  // main sequence
  // ------------------------------------------------
  initial begin
    access_t a;
    int      i;
    repeat (10) @(posedge clk_in);
    rstn_in <= 1'b1;
    reg_op(1'b0, CTRL_OFS, 32'h0);
    `CHK("ctrl reset", 32'h1, reg_rdata_out)
    reg_op(1'b0, 8'h20, 32'h0);
    `CHK("unmapped", 32'h0, reg_rdata_out)
    for (i = 0; i < SEG_COUNT; i++) begin
      seg_m[i] = $random(seed) & 32'h00FF_FFFF | (i == 3 ? 32'h8000_0000 : 32'h0);
      reg_op(1'b1, 8'h40 + 8'(4 * i), seg_m[i]);
      u_phr_mem.word_q[i] = $random(seed);
    end
    reg_op(1'b0, 8'h44, 32'h0);
    `CHK("segment", seg_m[1], reg_rdata_out)
    $display("register test done");
    for (i = 0; i < 300; i++) begin
      a = $bits(access_t)'({$random(seed), $random(seed), $random(seed)});
      a.valid    = 1'b1;
      a.pte_addr = {26'h0, a.pte_addr[5:2], 2'b00};
      a.is_touch = a.is_touch & a.ea[0];
      case (i)
        0: a.is_touch = 1'b1;
        1: a.bat_hit = 1'b1;
        2: a.ea[31:28] = 4'h3;
        3: a = '{valid: 1'b1, is_write: 1'b1, committed: 1'b1, default: '0};
        default: ;
      endcase
      if (a.tlb_hit) begin
        // a loaded copy has referenced set and mirrors memory, since stale copies are purged
        u_phr_mem.word_q[a.pte_addr[5:2]][R_BIT_POS] = 1'b1;
        a.tlb_c = u_phr_mem.word_q[a.pte_addr[5:2]][C_BIT_POS];
      end
      if (i % 100 == 50) begin
        rec = !rec;
        reg_op(1'b1, CTRL_OFS, {31'h0, rec});
      end
      @(posedge clk_in);
      instr_translate_enable_in <= ($random(seed) % 8) != 0;
      data_translate_enable_in  <= ($random(seed) % 8) != 0;
      slow                      <= $random(seed);
      run_acc(a);
    end
    reg_op(1'b0, COUNT_OFS, 32'h0);
    `CHK("update count", 32'(n_upd), reg_rdata_out)
    reg_op(1'b0, LAST_PTE_OFS, 32'h0);
    `CHK("last entry", last_pte, reg_rdata_out)
    reg_op(1'b0, STATUS_OFS, 32'h0);
    `CHK("status", {29'h0, st_exp, 1'b0}, reg_rdata_out)
    reg_op(1'b1, COUNT_OFS, 32'h5);
    reg_op(1'b0, COUNT_OFS, 32'h0);
    `CHK("count clear", 32'h0, reg_rdata_out)
    $display("access test done");
    close_out();
  end
endmodule : page_history_recording_test
